/* rtl/edrt_pkg.sv */
/*
 edrt_pkg: constants, types and register map of the repeat-transfer
 dma channel.
 assumes: a 32-bit apb register bus and a simple req/ack memory port.
*/
package edrt_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EDRT_OFF_MODE = 8'h00; // channel mode control
  localparam logic [7:0] EDRT_OFF_SRC = 8'h04; // source address
  localparam logic [7:0] EDRT_OFF_DST = 8'h08; // destination address
  localparam logic [7:0] EDRT_OFF_COUNT = 8'h0C; // total transfer count
  localparam logic [7:0] EDRT_OFF_BLOCK = 8'h10; // repeat block size
  localparam logic [7:0] EDRT_OFF_ACTRL = 8'h14; // address control
  localparam logic [7:0] EDRT_OFF_IRQ_ST = 8'h18; // interrupt status
  localparam logic [7:0] EDRT_OFF_IRQ_MSK = 8'h1C; // interrupt mask

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EDRT_BIT_ENABLE = 31; // transfer enable bit
  localparam int EDRT_BIT_END = 16; // transfer end flag in mode reg
  localparam int EDRT_BIT_IRQ_END = 0; // transfer end in irq regs
  localparam int EDRT_BIT_RSEL_LO = 0; // repeat area select lo
  localparam int EDRT_BIT_RSEL_HI = 1; // repeat area select hi
  localparam int EDRT_BIT_SIZE_LO = 4; // access size field, low bit
  localparam int EDRT_BIT_SIZE_HI = 5; // access size field, high bit
  localparam int EDRT_BLK_W = 16; // block size register width

  // ----------------------------------------------------------------
  // reset values: 512-byte total, 256-unit repeat block
  // ----------------------------------------------------------------
  localparam logic [31:0] EDRT_RST_COUNT = 32'h0000_0200;
  localparam logic [15:0] EDRT_RST_BLOCK = 16'h0100;
  localparam logic [31:0] EDRT_RST_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] EDRT_RSEL_SRC = 2'h1; // repeat on source
  localparam logic [1:0] EDRT_RSEL_DST = 2'h2; // repeat on destination
  localparam logic [1:0] EDRT_SIZE_BYTE = 2'h0; // 1-byte units
  localparam logic [1:0] EDRT_SIZE_WORD = 2'h1; // 2-byte units
  localparam logic [1:0] EDRT_SIZE_LONG = 2'h2; // 4-byte units

  // channel sequencer states
  typedef enum logic [1:0] {
    EDRT_ST_IDLE,
    EDRT_ST_READ,
    EDRT_ST_WRITE
  } edrt_state_e;

  // one memory access request, all fields registered
  typedef struct packed {
    logic req; // access requested
    logic we; // 1 write, 0 read
    logic [1:0] size; // access size code
    logic [31:0] addr; // byte address
    logic [31:0] wdata; // write data, low lanes
  } edrt_mem_req_s;

  // step in bytes for an access size code
  function automatic logic [31:0] edrt_step(input logic [1:0] sz);
    unique case (sz)
      EDRT_SIZE_WORD: edrt_step = 32'h0000_0002;
      EDRT_SIZE_LONG: edrt_step = 32'h0000_0004;
      default: edrt_step = 32'h0000_0001;
    endcase
  endfunction

endpackage

/* rtl/edrt_req_edge.sv */
/*
 edrt_req_edge: synchroniser and falling-edge detector for the
 external transfer request pin.
 assumes: the pin is asynchronous to ref_clk_in.
*/
`timescale 1ns/100ps
module edrt_req_edge import edrt_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic fall_out
);

  // ----------------------------------------------------------------
  // two-stage sync, then a history flop for the edge
  // ----------------------------------------------------------------
  logic sync1_reg; // first stage, read only by sync2_reg
  logic sync2_reg; // settled level
  logic prev_reg; // level one cycle earlier
  logic fall_reg; // one-cycle falling edge pulse

  // idle level is high so reset does not fake an edge
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
      fall_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      fall_reg <= prev_reg & ~sync2_reg;
    end
  end

  assign fall_out = fall_reg;

endmodule // edrt_req_edge

/* rtl/edrt_channel.sv */
/*
 edrt_channel: one external-bus dma channel in repeat transfer mode,
 dual-address cycle steal, with an apb register file and an interrupt.
 assumes: apb master per the protocol; memory answers each request
 with a one-cycle mem_ack_in, read data valid with that ack.
*/
// Behaviour
// - falling edge on request pin starts transfer
// - one access unit moved per request
// - total amount from 32-bit count register
// - repeat length from 16-bit block register
// - two select bits pick repeat side
// - block done reloads repeat side start address
// - blocks cycle until total amount moved
// - count zero runs free until disabled
// - addresses advance by access size each unit
// - defaults 512 bytes total, 256 block
// - only requests after enable are served
// - end flag set when count ends transfer
`timescale 1ns/100ps
module edrt_channel import edrt_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // request pin from the timer
  input wire logic external_transfer_request_pin_in,
  // memory port
  output edrt_mem_req_s mem_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  // interrupt
  output logic irq_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic enable_reg; // transfer enable bit
  logic end_flag_reg; // transfer end flag, sticky
  logic [31:0] src_start_reg; // software source start
  logic [31:0] dst_start_reg; // software destination start
  logic [31:0] src_cur_reg; // working source address
  logic [31:0] dst_cur_reg; // working destination address
  logic [31:0] count_reg; // remaining total, bytes
  logic [15:0] block_reg; // repeat block size, units
  logic [1:0] rsel_reg; // repeat area select pair
  logic [1:0] size_reg; // access size code
  logic irq_mask_reg; // mask for end flag
  logic [16:0] blk_left_reg; // units left in block
  logic pend_reg; // request waiting for the sequencer
  edrt_state_e state_reg; // sequencer state
  edrt_mem_req_s mem_reg; // registered memory request
  logic [31:0] prdata_reg; // apb read data
  logic pready_reg; // apb ready
  logic pslverr_reg; // apb error
  logic irq_reg; // interrupt level

  // ----------------------------------------------------------------
  // request edge detector
  // ----------------------------------------------------------------
  logic req_fall; // one-cycle pulse per falling edge

  edrt_req_edge u_req_edge (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(external_transfer_request_pin_in),
    .fall_out(req_fall)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = psel_in & ~penable_in; // setup phase
  wire acc = psel_in & penable_in & pready_reg; // completing access
  wire wr = acc & pwrite_in; // write takes effect here
  wire sel_mode = (paddr_in == EDRT_OFF_MODE);
  wire sel_src = (paddr_in == EDRT_OFF_SRC);
  wire sel_dst = (paddr_in == EDRT_OFF_DST);
  wire sel_count = (paddr_in == EDRT_OFF_COUNT);
  wire sel_block = (paddr_in == EDRT_OFF_BLOCK);
  wire sel_actrl = (paddr_in == EDRT_OFF_ACTRL);
  wire sel_irq_st = (paddr_in == EDRT_OFF_IRQ_ST);
  wire sel_irq_msk = (paddr_in == EDRT_OFF_IRQ_MSK);
  wire mapped = sel_mode | sel_src | sel_dst | sel_count | sel_block
    | sel_actrl | sel_irq_st | sel_irq_msk;

  // software enable write, and the rising edge of enable it makes
  wire wr_mode = wr & sel_mode;
  wire sw_enable = pwdata_in[EDRT_BIT_ENABLE];
  wire enable_rise = wr_mode & sw_enable & ~enable_reg;
  // end flag is one bit visible at two places, write one clears
  wire end_clear = (wr_mode & pwdata_in[EDRT_BIT_END])
    | (wr & sel_irq_st & pwdata_in[EDRT_BIT_IRQ_END]);

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = EDRT_RST_ZERO;
    rd_mux[EDRT_BIT_ENABLE] = sel_mode & enable_reg;
    rd_mux[EDRT_BIT_END] = sel_mode & end_flag_reg;
    if (sel_src) begin
      rd_mux = src_cur_reg;
    end
    if (sel_dst) begin
      rd_mux = dst_cur_reg;
    end
    if (sel_count) begin
      rd_mux = count_reg;
    end
    if (sel_block) begin
      rd_mux[EDRT_BLK_W-1:0] = block_reg;
    end
    if (sel_actrl) begin
      rd_mux[EDRT_BIT_RSEL_HI:EDRT_BIT_RSEL_LO] = rsel_reg;
      rd_mux[EDRT_BIT_SIZE_HI:EDRT_BIT_SIZE_LO] = size_reg;
    end
    if (sel_irq_st) begin
      rd_mux[EDRT_BIT_IRQ_END] = end_flag_reg;
    end
    if (sel_irq_msk) begin
      rd_mux[EDRT_BIT_IRQ_END] = irq_mask_reg;
    end
  end

  // ----------------------------------------------------------------
  // transfer datapath decode
  // ----------------------------------------------------------------
  wire [31:0] step = edrt_step(size_reg);
  wire unit_done = (state_reg == EDRT_ST_WRITE) & mem_ack_in;
  wire free_run = (count_reg == EDRT_RST_ZERO);
  wire [31:0] count_dec = (count_reg <= step) ? EDRT_RST_ZERO
    : (count_reg - step);
  // counted transfer finishes on this unit
  wire last_unit = unit_done & ~free_run & (count_dec == EDRT_RST_ZERO);
  wire blk_end = (blk_left_reg == 17'h0_0001);
  // block size zero stands for the full 64K units
  wire [16:0] blk_load = {(block_reg == 16'h0000), block_reg};
  wire rep_src = (rsel_reg == EDRT_RSEL_SRC);
  wire rep_dst = (rsel_reg == EDRT_RSEL_DST);
  wire start = (state_reg == EDRT_ST_IDLE) & pend_reg & enable_reg;

  // next working addresses after a finished unit
  wire [31:0] src_adv = (blk_end & rep_src) ? src_start_reg
    : (src_cur_reg + step);
  wire [31:0] dst_adv = (blk_end & rep_dst) ? dst_start_reg
    : (dst_cur_reg + step);

  // ----------------------------------------------------------------
  // sequencer: read source, then write destination
  // ----------------------------------------------------------------
  edrt_state_e state_next;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      EDRT_ST_IDLE: begin
        if (start) begin
          state_next = EDRT_ST_READ;
        end
      end
      EDRT_ST_READ: begin
        if (mem_ack_in) begin
          state_next = EDRT_ST_WRITE;
        end
      end
      EDRT_ST_WRITE: begin
        if (mem_ack_in) begin
          state_next = EDRT_ST_IDLE;
        end
      end
    endcase
  end

  // memory request for the next cycle
  edrt_mem_req_s mem_next;
  always_comb begin
    mem_next = mem_reg;
    mem_next.size = size_reg;
    if (start) begin
      mem_next.req = 1'b1;
      mem_next.we = 1'b0;
      mem_next.addr = src_cur_reg;
    end else if ((state_reg == EDRT_ST_READ) & mem_ack_in) begin
      mem_next.we = 1'b1;
      mem_next.addr = dst_cur_reg;
      mem_next.wdata = mem_rdata_in;
    end else if (unit_done) begin
      mem_next.req = 1'b0;
      mem_next.we = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer and memory port flops
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= EDRT_ST_IDLE;
      mem_reg <= '0;
    end else begin
      state_reg <= state_next;
      // read data rides in mem_reg.wdata, no extra holding flop
      mem_reg <= mem_next;
    end
  end

  // ----------------------------------------------------------------
  // request pending latch
  // ----------------------------------------------------------------
  // edges while disabled are dropped, so only requests after enable
  // count; one request may wait while a unit is in flight
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pend_reg <= 1'b0;
    end else if (~enable_reg | last_unit) begin
      pend_reg <= 1'b0;
    end else if (req_fall) begin
      pend_reg <= 1'b1;
    end else if (start) begin
      pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // enable bit and end flag
  // ----------------------------------------------------------------
  // hardware clear at the end beats a same-cycle software write
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      enable_reg <= 1'b0;
    end else if (last_unit) begin
      enable_reg <= 1'b0;
    end else if (wr_mode) begin
      enable_reg <= sw_enable;
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      end_flag_reg <= 1'b0;
    end else if (last_unit) begin
      end_flag_reg <= 1'b1;
    end else if (end_clear) begin
      end_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // address, count and block registers
  // ----------------------------------------------------------------
  // software writes land in both start and working copies; a write
  // during a live unit wins over the hardware advance
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      src_start_reg <= EDRT_RST_ZERO;
      src_cur_reg <= EDRT_RST_ZERO;
      dst_start_reg <= EDRT_RST_ZERO;
      dst_cur_reg <= EDRT_RST_ZERO;
    end else begin
      if (wr & sel_src) begin
        src_start_reg <= pwdata_in;
        src_cur_reg <= pwdata_in;
      end else if (unit_done) begin
        src_cur_reg <= src_adv;
      end
      if (wr & sel_dst) begin
        dst_start_reg <= pwdata_in;
        dst_cur_reg <= pwdata_in;
      end else if (unit_done) begin
        dst_cur_reg <= dst_adv;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= EDRT_RST_COUNT;
    end else if (wr & sel_count) begin
      count_reg <= pwdata_in;
    end else if (unit_done & ~free_run) begin
      count_reg <= count_dec;
    end
  end

  // block counter restarts at enable and after each full block
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      blk_left_reg <= {1'b0, EDRT_RST_BLOCK};
    end else if (enable_rise) begin
      blk_left_reg <= blk_load;
    end else if (unit_done) begin
      blk_left_reg <= blk_end ? blk_load
        : (blk_left_reg - 17'h0_0001);
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      block_reg <= EDRT_RST_BLOCK;
      rsel_reg <= EDRT_RSEL_SRC;
      size_reg <= EDRT_SIZE_BYTE;
      irq_mask_reg <= 1'b0;
    end else begin
      if (wr & sel_block) begin
        block_reg <= pwdata_in[EDRT_BLK_W-1:0];
      end
      if (wr & sel_actrl) begin
        rsel_reg <= pwdata_in[EDRT_BIT_RSEL_HI:EDRT_BIT_RSEL_LO];
        size_reg <= pwdata_in[EDRT_BIT_SIZE_HI:EDRT_BIT_SIZE_LO];
      end
      if (wr & sel_irq_msk) begin
        irq_mask_reg <= pwdata_in[EDRT_BIT_IRQ_END];
      end
    end
  end

  // ----------------------------------------------------------------
  // apb answer and interrupt
  // ----------------------------------------------------------------
  // ready one cycle after setup, so every access has one wait-free
  // access phase and read data is registered in time
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_reg <= EDRT_RST_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup) begin
        prdata_reg <= rd_mux;
      end
      irq_reg <= end_flag_reg & irq_mask_reg;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign mem_out = mem_reg;
  assign irq_out = irq_reg;

endmodule // edrt_channel

/* tb/edrt_assertions.sv */
/*
 edrt_assertions: port-level checks of the repeat-transfer channel.
 assumes: bound to edrt_channel, one clock, async active-high reset.
*/
`timescale 1ns/100ps
module edrt_assertions import edrt_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic external_transfer_request_pin_in,
  input wire edrt_mem_req_s mem_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  input wire logic irq_out
);
  // ------
  // helper decodes
  // ------
  wire logic acc = psel_in && penable_in && pready_out && pwrite_in;
  // only aligned words up to the mask register are decoded
  wire logic unmapped = paddr_in > EDRT_OFF_IRQ_MSK || paddr_in[1:0] != 2'h0;
  wire logic rd_ack = mem_out.req && !mem_out.we && mem_ack_in;
  wire logic wr_ack = mem_out.req && mem_out.we && mem_ack_in;
  wire logic msk_wr = acc && (paddr_in == EDRT_OFF_IRQ_MSK);
  // a clear at either place or a mask-off drops the line
  wire logic clr_wr = acc && ((paddr_in == EDRT_OFF_IRQ_ST && pwdata_in[0])
    || (paddr_in == EDRT_OFF_MODE && pwdata_in[EDRT_BIT_END])
    || (msk_wr && !pwdata_in[0]));

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  // ------
  // assertions
  // ------
  chk_pready_once: assert property (psel_in && !penable_in
    |=> pready_out ##1 !pready_out)
    else $error("pready not a single access cycle");
  chk_unmapped_err: assert property (psel_in && !penable_in
    |=> pslverr_out == $past(unmapped))
    else $error("pslverr does not match address decode");
  chk_read_first: assert property ($rose(mem_out.req) |-> !mem_out.we)
    else $error("unit did not open with a read");
  chk_write_after: assert property (rd_ack |=> mem_out.req && mem_out.we
    && mem_out.wdata == $past(mem_rdata_in))
    else $error("write did not follow read with its data");
  chk_unit_end: assert property (wr_ack |=> !mem_out.req)
    else $error("request stayed up after write ack");
  chk_req_hold: assert property (mem_out.req && !mem_ack_in
    |=> $stable(mem_out))
    else $error("memory request changed before ack");
  chk_irq_rise: assert property ($rose(irq_out)
    |-> $past(wr_ack, 2) || $past(msk_wr, 2))
    else $error("interrupt rose without unit end or unmask");
  chk_irq_clear: assert property (clr_wr |-> ##2 !irq_out)
    else $error("interrupt still high after clear");

  // main scenarios reached
  cover property (wr_ack);
  cover property ($rose(irq_out));
  cover property (psel_in && pslverr_out);
endmodule // edrt_assertions

bind edrt_channel edrt_assertions chk_i (
  .ref_clk_in(ref_clk_in),
  .reset_in(reset_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .external_transfer_request_pin_in(external_transfer_request_pin_in),
  .mem_out(mem_out),
  .mem_ack_in(mem_ack_in),
  .mem_rdata_in(mem_rdata_in),
  .irq_out(irq_out)
);

/* tb/edrt_mem_model.sv */
/*
 edrt_mem_model: behavioural external memory on the dma port.
 assumes: request held until ack, one access outstanding at a time.
*/
`timescale 1ns/100ps
module edrt_mem_model import edrt_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire edrt_mem_req_s mem_in,
  input wire logic [3:0] lat_in,
  output logic ack_out,
  output logic [31:0] rdata_out
);
  // ------
  // access log, read by the bench
  // ------
  logic [31:0] ra [0:1023]; // read addresses
  logic [31:0] wa [0:1023]; // write addresses
  logic [31:0] wd [0:1023]; // write data
  int n; // finished units
  int rn; // finished reads
  logic [3:0] wait_reg; // cycles waited so far

  // answer after lat_in cycles; idle data flips so nothing stale passes
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_out <= 1'b0;
      wait_reg <= 4'h0;
      n <= 0;
      rn <= 0;
      rdata_out <= 32'h0;
    end else if (ack_out || !mem_in.req) begin
      ack_out <= 1'b0;
      wait_reg <= 4'h0;
      rdata_out <= ~rdata_out;
    end else if (wait_reg < lat_in) begin
      wait_reg <= wait_reg + 4'h1;
      rdata_out <= ~rdata_out;
    end else begin
      ack_out <= 1'b1;
      if (mem_in.we) begin
        wa[n] <= mem_in.addr;
        wd[n] <= mem_in.wdata;
        n <= n + 1;
      end else begin
        ra[rn] <= mem_in.addr;
        rn <= rn + 1;
        rdata_out <= {24'h0, mem_in.addr[7:0] ^ 8'h5A};
      end
    end
  end
endmodule // edrt_mem_model

/* tb/edrt_tb.sv */
/*
 testbench: self-checking bench of the repeat-transfer channel.
 assumes: edrt_channel, edrt_mem_model and the bound checker.
*/
`timescale 1ns/100ps
module testbench import edrt_pkg::*;;
  // ------
  // stimulus and wiring
  // ------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic req_pin = 1'b1; // timer output idles high
  logic [3:0] lat = 4'h0; // memory latency
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ack;
  logic [31:0] rdata;
  logic irq;
  edrt_mem_req_s mem;
  int checks = 0;
  int miscompares = 0;

  edrt_channel uut (.ref_clk_in(ref_clk), .reset_in(reset),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .external_transfer_request_pin_in(req_pin), .mem_out(mem),
    .mem_ack_in(ack), .mem_rdata_in(rdata), .irq_out(irq));
  edrt_mem_model mem_i (.ref_clk_in(ref_clk), .reset_in(reset),
    .mem_in(mem), .lat_in(lat), .ack_out(ack), .rdata_out(rdata));

  // 100 mhz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ------
  // shared tasks
  // ------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    if (k >= 8) begin
      miscompares++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
  endtask

  // one falling edge, then wait for the unit or give up
  task automatic pulse();
    int n0 = mem_i.n;
    int k = 0;
    @(posedge ref_clk);
    req_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    req_pin <= 1'b1;
    while (mem_i.n == n0 && k < 40) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (2) @(posedge ref_clk);
  endtask

  // logged addresses and data against the repeat arithmetic
  task automatic units(input int b, input int cnt, input logic [31:0] s,
      input logic [31:0] d, input int blk, input logic [1:0] sel,
      input logic [31:0] st);
    logic [31:0] es;
    logic [31:0] ed;
    for (int i = 0; i < cnt; i++) begin
      es = s + st * 32'((sel == EDRT_RSEL_SRC) ? i % blk : i);
      ed = d + st * 32'((sel == EDRT_RSEL_DST) ? i % blk : i);
      check(mem_i.ra[b + i], es);
      check(mem_i.wa[b + i], ed);
      check(mem_i.wd[b + i], {24'h0, es[7:0] ^ 8'h5A});
    end
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rdc(EDRT_OFF_MODE, EDRT_RST_ZERO);
    rdc(EDRT_OFF_COUNT, EDRT_RST_COUNT);
    rdc(EDRT_OFF_BLOCK, {16'h0, EDRT_RST_BLOCK});
    rdc(EDRT_OFF_ACTRL, 32'h1);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    pulse();
    check(32'(mem_i.n), 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_default();
    int b = mem_i.n;
    wr(EDRT_OFF_SRC, 32'h1000);
    wr(EDRT_OFF_DST, 32'h8000);
    wr(EDRT_OFF_IRQ_MSK, 32'h1);
    wr(EDRT_OFF_MODE, 32'h8000_0000);
    repeat (512) pulse();
    check(32'(mem_i.n - b), 32'h200);
    units(b, 512, 32'h1000, 32'h8000, 256, EDRT_RSEL_SRC, 32'h1);
    rdc(EDRT_OFF_MODE, 32'h0001_0000);
    rdc(EDRT_OFF_COUNT, EDRT_RST_ZERO);
    check({31'h0, irq}, 32'h1);
    pulse();
    check(32'(mem_i.n - b), 32'h200);
    wr(EDRT_OFF_IRQ_ST, 32'h1);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    rdc(EDRT_OFF_MODE, EDRT_RST_ZERO);
    $display("t_default done");
  endtask

  // word units, repeat on the destination, slow memory, irq masked
  task automatic t_dst_word();
    int b = mem_i.n;
    lat <= 4'h4;
    wr(EDRT_OFF_IRQ_MSK, 32'h0);
    wr(EDRT_OFF_SRC, 32'h200);
    wr(EDRT_OFF_DST, 32'h400);
    wr(EDRT_OFF_COUNT, 32'h8);
    wr(EDRT_OFF_BLOCK, 32'h2);
    wr(EDRT_OFF_ACTRL, 32'h12);
    wr(EDRT_OFF_MODE, 32'h8000_0000);
    repeat (4) pulse();
    check(32'(mem_i.n - b), 32'h4);
    units(b, 4, 32'h200, 32'h400, 2, EDRT_RSEL_DST, 32'h2);
    check({31'h0, irq}, 32'h0);
    wr(EDRT_OFF_IRQ_MSK, 32'h1);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h1);
    wr(EDRT_OFF_IRQ_ST, 32'h1);
    lat <= 4'h1;
    $display("t_dst_word done");
  endtask

  // long units, no repeat side, end flag cleared in the mode register
  task automatic t_long();
    int b = mem_i.n;
    wr(EDRT_OFF_SRC, 32'h40);
    wr(EDRT_OFF_DST, 32'h80);
    wr(EDRT_OFF_COUNT, 32'h8);
    wr(EDRT_OFF_ACTRL, 32'h20);
    wr(EDRT_OFF_MODE, 32'h8000_0000);
    repeat (2) pulse();
    check(32'(mem_i.n - b), 32'h2);
    units(b, 2, 32'h40, 32'h80, 1, 2'h0, 32'h4);
    check({31'h0, irq}, 32'h1);
    wr(EDRT_OFF_MODE, 32'h0001_0000);
    rdc(EDRT_OFF_MODE, EDRT_RST_ZERO);
    $display("t_long done");
  endtask

  task automatic t_free();
    int b = mem_i.n;
    wr(EDRT_OFF_SRC, 32'h300);
    wr(EDRT_OFF_DST, 32'h600);
    wr(EDRT_OFF_COUNT, 32'h0);
    wr(EDRT_OFF_BLOCK, 32'h3);
    wr(EDRT_OFF_ACTRL, 32'h1);
    wr(EDRT_OFF_MODE, 32'h8000_0000);
    repeat (7) pulse();
    check(32'(mem_i.n - b), 32'h7);
    units(b, 7, 32'h300, 32'h600, 3, EDRT_RSEL_SRC, 32'h1);
    rdc(EDRT_OFF_MODE, 32'h8000_0000);
    wr(EDRT_OFF_MODE, 32'h0);
    pulse();
    check(32'(mem_i.n - b), 32'h7);
    $display("t_free done");
  endtask

  // ------
  // run control
  // ------
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, well past the ~6.5k cycles the tests need
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_default();
    t_dst_word();
    t_long();
    t_free();
    complete_run();
  end
endmodule // testbench
